// ---- wps_top.sv ----
// Top: reset control, mode decode and power sequencing
`timescale 1ns/10ps
`include "wps_cfg.svh"
module wps_top #(
   parameter int MS_CYCLES  = `WPS_MS_CYC,
   parameter int DGL_CYCLES = `WPS_DGL_CYC
) (
   // Clock, reset, enable
   input  wire logic       MCLK,
   input  wire logic       SRST,
   input  wire logic       CE,
   // Command bytes from bus front end
   input  wire logic [7:0] CMD_BYTE,
   input  wire logic       CMD_VALID,
   // Enable select pins
   input  wire logic       ENABLE_SELECT_A,
   input  wire logic       ENABLE_SELECT_B,
   // Analog comparator flags
   input  wire logic [5:0] CMP_STD,
   input  wire logic [5:0] CMP_INV,
   input  wire logic [1:0] OUT_OF_REG,
   input  wire logic       RC_TIMER_DONE,
   // Open-drain reset pin
   output logic            RESET_O,
   output logic            RESET_OE,
   // Regulator controls
   output logic            SW_EN,
   output logic            LIN_EN,
   output logic            SW_SINK_ON,
   output logic            SW_SHUNT_ON,
   output logic            LIN_SHUNT_ON,
   output logic            LIN_SINK_ON,
   // Status
   output logic            WD_ACTIVE,
   output logic [1:0]      OP_MODE
);
   localparam int SW = 17;
   wps_wd_if wd ();
   logic [SW-1:0] syn;
   logic [5:0]    cstd_s, cinv_s;
   logic [1:0]    oor_s, pins_s;
   logic          rc_s;
   wps_pkg::wps_mode_type mode_q, mode_d;
   logic [15:0]   tick_cnt_q, tick_cnt_d;
   logic          tick_q, tick_d;
   logic [15:0]   dgl_q, dgl_d;
   logic          fault_q, fault_d;
   wps_pkg::wps_rst_type rs_q, rs_d;
   logic [3:0]    rdly_q, rdly_d;
   logic          rst_oe_q, rst_o_q;
   logic [5:0]    cmp_q, cmp_d;
   logic          poff_q, poff_d, psh_q, psh_d;
   logic          soff_q, soff_d, ssk_q, ssk_d;
   logic          sw_off, lin_off, seq_on;
   logic [5:0]    out_q, out_d;

   // =====================================================
   // Input synchronisers for every pin and analog flag
   wps_sync #(.W(SW)) u_sync (
      .mclk     (MCLK),
      .srst     (SRST),
      .ce       (CE),
      .async_in ({RC_TIMER_DONE, OUT_OF_REG, CMP_INV, CMP_STD,
                  ENABLE_SELECT_A, ENABLE_SELECT_B}),
      .sync_out (syn)
   );
   assign {rc_s, oor_s, cinv_s, cstd_s, pins_s} = syn;

   // =====================================================
   // Watchdog
   assign wd.ms_tick   = tick_q;
   assign wd.cmd_valid = CMD_VALID;
   assign wd.cmd_byte  = CMD_BYTE;
   wps_wdog u_wdog (
      .mclk (MCLK),
      .srst (SRST),
      .ce   (CE),
      .wd   (wd.wdog)
   );

   // =====================================================
   // Millisecond tick, fault deglitch, mode decode
   always_comb begin
      tick_d     = 1'b0;
      tick_cnt_d = tick_cnt_q + 16'h0001;
      if (tick_cnt_q == 16'(MS_CYCLES - 1)) begin
         tick_cnt_d = 16'h0000;
         tick_d     = 1'b1;
      end
      // Short dips below the filter time never reach the pin
      fault_d = 1'b0;
      dgl_d   = 16'h0000;
      if (|oor_s) begin
         fault_d = fault_q;
         dgl_d   = dgl_q + 16'h0001;
         if (dgl_q == 16'(DGL_CYCLES - 1)) begin
            fault_d = 1'b1;
            dgl_d   = dgl_q;
         end
      end
      // Pulled-down pins arrive low when floating
      mode_d = wps_pkg::wps_mode_type'(pins_s);
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         tick_cnt_q <= 16'h0000;
         tick_q     <= 1'b0;
         dgl_q      <= 16'h0000;
         fault_q    <= 1'b0;
         mode_q     <= wps_pkg::MODE_OFF;
      end else if (CE) begin
         tick_cnt_q <= tick_cnt_d;
         tick_q     <= tick_d;
         dgl_q      <= dgl_d;
         fault_q    <= fault_d;
         mode_q     <= mode_d;
      end
   end

   // =====================================================
   // Reset sequencer: fixed 10 ms, then the external RC delay
   always_comb begin
      rs_d   = rs_q;
      rdly_d = rdly_q;
      unique case (rs_q)
         wps_pkg::RS_DELAY: begin
            if (tick_q) begin
               if (rdly_q == `WPS_RST_MS - 4'h1) begin
                  rs_d = wps_pkg::RS_RC;
               end else begin
                  rdly_d = rdly_q + 4'h1;
               end
            end
         end
         wps_pkg::RS_RC: begin
            if (rc_s) begin
               rs_d = wps_pkg::RS_DONE;
            end
         end
         wps_pkg::RS_DONE: begin
            rs_d = wps_pkg::RS_DONE;
         end
      endcase
      // Either cause restarts the whole delay
      if (fault_q || wd.expire) begin
         rs_d   = wps_pkg::RS_DELAY;
         rdly_d = 4'h0;
      end
   end

   // Power-on enters the delay state holding reset low
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         rs_q     <= wps_pkg::RS_DELAY;
         rdly_q   <= 4'h0;
         rst_oe_q <= 1'b1;
         rst_o_q  <= 1'b0;
      end else if (CE) begin
         rs_q     <= rs_d;
         rdly_q   <= rdly_d;
         rst_oe_q <= (rs_d != wps_pkg::RS_DONE);
         rst_o_q  <= (rs_d == wps_pkg::RS_DONE);
      end
   end

   // =====================================================
   // Sequencing: primary pair guards the low rail's excess,
   // secondary pair the reverse polarity
   always_comb begin
      // Registered flags, picked for the active polarity
      cmp_d  = (mode_d == wps_pkg::MODE_INV) ? cinv_s : cstd_s;
      seq_on = (mode_q == wps_pkg::MODE_STD) ||
               (mode_q == wps_pkg::MODE_INV);
      poff_d = poff_q;
      psh_d  = psh_q;
      soff_d = soff_q;
      ssk_d  = ssk_q;
      if (cmp_q[`WPS_F_SHUNT]) begin
         poff_d = 1'b1; // Shunt beats cancel
         psh_d  = 1'b1;
      end else if (cmp_q[`WPS_F_OFF]) begin
         poff_d = 1'b1;
      end else if (cmp_q[`WPS_F_CANCEL]) begin
         poff_d = 1'b0;
         psh_d  = 1'b0;
      end
      if (cmp_q[`WPS_F_SINK]) begin
         soff_d = 1'b1;
         ssk_d  = 1'b1;
      end else if (cmp_q[`WPS_F_SOFF]) begin
         soff_d = 1'b1;
      end else if (cmp_q[`WPS_F_REL]) begin
         soff_d = 1'b0;
         ssk_d  = 1'b0;
      end
      // Mode change drops stale actions; no-seq mode has none
      if (!seq_on || mode_d != mode_q) begin
         poff_d = 1'b0;
         psh_d  = 1'b0;
         soff_d = 1'b0;
         ssk_d  = 1'b0;
      end
      lin_off = (mode_q == wps_pkg::MODE_STD) ? poff_d : soff_d;
      sw_off  = (mode_q == wps_pkg::MODE_STD) ? soff_d : poff_d;
      // Order: sw_en lin_en sw_sink sw_shunt lin_shunt lin_sink
      out_d[0] = (mode_q != wps_pkg::MODE_OFF) && !sw_off;
      out_d[1] = (mode_q != wps_pkg::MODE_OFF) && !lin_off;
      out_d[2] = (mode_q == wps_pkg::MODE_STD) && ssk_d;
      out_d[3] = (mode_q == wps_pkg::MODE_INV) && psh_d;
      out_d[4] = (mode_q == wps_pkg::MODE_STD) && psh_d;
      out_d[5] = (mode_q == wps_pkg::MODE_INV) && ssk_d;
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         cmp_q  <= 6'h00;
         poff_q <= 1'b0;
         psh_q  <= 1'b0;
         soff_q <= 1'b0;
         ssk_q  <= 1'b0;
         out_q  <= 6'h00;
      end else if (CE) begin
         cmp_q  <= cmp_d;
         poff_q <= poff_d;
         psh_q  <= psh_d;
         soff_q <= soff_d;
         ssk_q  <= ssk_d;
         out_q  <= out_d;
      end
   end

   // Outputs, all from flops
   assign RESET_OE     = rst_oe_q;
   assign RESET_O      = rst_o_q;
   assign {LIN_SINK_ON, LIN_SHUNT_ON, SW_SHUNT_ON,
           SW_SINK_ON, LIN_EN, SW_EN} = out_q;
   assign WD_ACTIVE    = wd.active;
   assign OP_MODE      = mode_q;

   // =====================================================
   // Checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SRST);
   property p_delay_len;
      CE && rs_q == wps_pkg::RS_RC && $past(rs_q) == wps_pkg::RS_DELAY
         |-> $past(rdly_q) == 4'h9 && $past(tick_q);
   endproperty
   a_delay_len: assert property (p_delay_len)
      else $error("reset delay not 10 ms");
   property p_delay_hold;
      rs_q != wps_pkg::RS_DONE |-> RESET_OE;
   endproperty
   a_delay_hold: assert property (p_delay_hold)
      else $error("reset released during delay");
   property p_trig;
      CE && (fault_q || wd.expire) |=> RESET_OE && rdly_q == 4'h0;
   endproperty
   a_trig: assert property (p_trig)
      else $error("reset not asserted on fault or expiry");
   property p_std_off;
      CE && mode_q == wps_pkg::MODE_STD && mode_d == mode_q &&
         cmp_q[`WPS_F_OFF] |=> !LIN_EN;
   endproperty
   a_std_off: assert property (p_std_off)
      else $error("linear not forced off");
   property p_shunt_prio;
      CE && mode_q == wps_pkg::MODE_STD && mode_d == mode_q &&
         cmp_q[`WPS_F_SHUNT] && cmp_q[`WPS_F_CANCEL]
         |=> LIN_SHUNT_ON && !LIN_EN;
   endproperty
   a_shunt_prio: assert property (p_shunt_prio)
      else $error("shunt lost to cancel");
   property p_std_sink;
      CE && mode_q == wps_pkg::MODE_STD && mode_d == mode_q &&
         cmp_q[`WPS_F_SINK] |=> SW_SINK_ON && !SW_EN;
   endproperty
   a_std_sink: assert property (p_std_sink)
      else $error("switcher sink not applied");
   property p_inv_act;
      CE && mode_q == wps_pkg::MODE_INV && mode_d == mode_q &&
         cmp_q[`WPS_F_SHUNT] && cmp_q[`WPS_F_SINK]
         |=> SW_SHUNT_ON && LIN_SINK_ON && !SW_EN && !LIN_EN;
   endproperty
   a_inv_act: assert property (p_inv_act)
      else $error("inverted actions missing");
   property p_noseq;
      CE && mode_q == wps_pkg::MODE_ALL
         |=> SW_EN && LIN_EN && !(|out_q[5:2]);
   endproperty
   a_noseq: assert property (p_noseq)
      else $error("action in no-sequencing mode");
   property p_off;
      CE && mode_q == wps_pkg::MODE_OFF |=> !SW_EN && !LIN_EN;
   endproperty
   a_off: assert property (p_off)
      else $error("regulators on in disabled mode");
   c_release: cover property ($fell(RESET_OE));
   c_shunt: cover property ($rose(LIN_SHUNT_ON));
   c_inv: cover property ($rose(LIN_SINK_ON));
endmodule : wps_top

// ---- wps_cfg.svh ----
// Constants for the watchdog and power-sequencing control block
// Overview of operation
// - Watchdog idle until programming byte arrives
// - Second byte low bits pick period
// - Any period-setting byte switches watchdog on
// - New programming command restarts timer from zero
// - Expiry drives reset low for delay
// - Watchdog stays off after expiry reset
// - Window mode ignores clears in first half
// - Enable pins decode four operating modes
// - Undriven enable pins read low, disabled
// - Standard: linear forced off above 1.8 V
// - Standard: linear shunt above 1.9 V
// - Standard: below 1.7 V cancel, re-enable linear
// - Standard: switcher off at 0.2 V below
// - Standard: sync and sink on at 0.3 V
// - Standard: release when linear above switcher
// - Inverted: switcher off, shunt, cancel likewise
// - Inverted: linear off, sink, release likewise
// - No-sequencing mode suppresses actions, both enabled
// - Deglitched out-of-regulation pulls reset low
// - Power-up reset held 10 ms plus RC
`ifndef WPS_CFG_SVH
`define WPS_CFG_SVH
// =====================================================
// Timing
`define WPS_CLK_PS   25000
`define WPS_MS_PS    1000000000
`define WPS_MS_CYC   (`WPS_MS_PS / `WPS_CLK_PS)
`define WPS_DGL_PS   20000000
`define WPS_DGL_CYC  (`WPS_DGL_PS / `WPS_CLK_PS)
`define WPS_RST_MS   4'hA
`define WPS_WD_P0    11'h500
`define WPS_WD_P1    11'h140
`define WPS_WD_P2    11'h050
`define WPS_WD_P3    11'h014
// =====================================================
// Command byte layout
`define WPS_CMD_FIRST 8'h60
`define WPS_CMD_ADDR  4'h6
`define WPS_CMD_ON    3
`define WPS_CMD_WIN   2
// =====================================================
// Comparator flag positions
`define WPS_F_OFF     0
`define WPS_F_SHUNT   1
`define WPS_F_CANCEL  2
`define WPS_F_SOFF    3
`define WPS_F_SINK    4
`define WPS_F_REL     5
`endif

// ---- wps_pkg.sv ----
// Types shared by the watchdog and power-sequencing control block
package wps_pkg;
   typedef enum logic [1:0] {
      MODE_OFF = 2'h0, MODE_STD = 2'h1, MODE_INV = 2'h2, MODE_ALL = 2'h3
   } wps_mode_type;
   typedef enum logic [2:0] {
      RS_DELAY = 3'h1, RS_RC = 3'h2, RS_DONE = 3'h4
   } wps_rst_type;
   typedef enum logic [1:0] {
      CS_IDLE = 2'h1, CS_ARMED = 2'h2
   } wps_cmd_type;
endpackage : wps_pkg

// ---- wps_wd_if.sv ----
// Connection between the control top and the watchdog
`timescale 1ns/10ps
interface wps_wd_if;
   logic       ms_tick;
   logic       cmd_valid;
   logic [7:0] cmd_byte;
   logic       active;
   logic       expire;
   modport host (output ms_tick, cmd_valid, cmd_byte,
                 input active, expire);
   modport wdog (input ms_tick, cmd_valid, cmd_byte,
                 output active, expire);
endinterface : wps_wd_if

// ---- wps_sync.sv ----
// Two-stage synchroniser for pins and comparator flags
`timescale 1ns/10ps
module wps_sync #(
   parameter int W = 1
) (
   // Clock, reset, enable
   input  wire logic         mclk,
   input  wire logic         srst,
   input  wire logic         ce,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   // =====================================================
   // One flop pair per bit; the first stage feeds only the second
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk) begin
         if (srst) begin
            meta_q[i]   <= 1'b0;
            sync_out[i] <= 1'b0;
         end else if (ce) begin
            meta_q[i]   <= async_in[i];
            sync_out[i] <= meta_q[i];
         end
      end
   end
endmodule : wps_sync

// ---- wps_wdog.sv ----
// Watchdog timer programmed by command bytes
`timescale 1ns/10ps
`include "wps_cfg.svh"
module wps_wdog (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   // Link to top
   wps_wd_if.wdog   wd
);
   wps_pkg::wps_cmd_type cs_q, cs_d;
   logic        active_q, active_d, win_q, win_d, exp_q, exp_d;
   logic [1:0]  per_q, per_d;
   logic [10:0] cnt_q, cnt_d, limit;
   logic        closed, wd_cmd, take;

   // =====================================================
   // Next state: command decode and timing
   always_comb begin
      unique case (per_q)
         2'h0: limit = `WPS_WD_P0;
         2'h1: limit = `WPS_WD_P1;
         2'h2: limit = `WPS_WD_P2;
         2'h3: limit = `WPS_WD_P3;
      endcase
      closed   = win_q && (cnt_q < (limit >> 1));
      wd_cmd   = wd.cmd_valid && (cs_q == wps_pkg::CS_ARMED)
                 && (wd.cmd_byte[7:4] == `WPS_CMD_ADDR);
      // A running window watchdog refuses early clears
      take     = wd_cmd && wd.cmd_byte[`WPS_CMD_ON]
                 && !(active_q && closed);
      cs_d     = cs_q;
      active_d = active_q;
      win_d    = win_q;
      per_d    = per_q;
      cnt_d    = cnt_q;
      exp_d    = 1'b0;
      if (wd.cmd_valid) begin
         cs_d = (cs_q == wps_pkg::CS_IDLE &&
                 wd.cmd_byte == `WPS_CMD_FIRST) ?
                wps_pkg::CS_ARMED : wps_pkg::CS_IDLE;
      end
      if (wd_cmd && wd.cmd_byte[3:0] == 4'h0) begin
         active_d = 1'b0; // Off code
         cnt_d    = 11'h000;
      end else if (take) begin
         active_d = 1'b1;
         win_d    = wd.cmd_byte[`WPS_CMD_WIN];
         per_d    = wd.cmd_byte[1:0];
         cnt_d    = 11'h000;
      end else if (active_q && wd.ms_tick) begin
         if (cnt_q == limit - 11'h001) begin
            active_d = 1'b0;
            exp_d    = 1'b1;
         end else begin
            cnt_d = cnt_q + 11'h001;
         end
      end
   end

   // Registers; watchdog starts inactive
   always_ff @(posedge mclk) begin
      if (srst) begin
         cs_q     <= wps_pkg::CS_IDLE;
         active_q <= 1'b0;
         win_q    <= 1'b0;
         per_q    <= 2'h0;
         cnt_q    <= 11'h000;
         exp_q    <= 1'b0;
      end else if (ce) begin
         cs_q     <= cs_d;
         active_q <= active_d;
         win_q    <= win_d;
         per_q    <= per_d;
         cnt_q    <= cnt_d;
         exp_q    <= exp_d;
      end
   end

   assign wd.active = active_q;
   assign wd.expire = exp_q;

   // =====================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   property p_wd_start;
      ce && take |=> active_q && cnt_q == 11'h000;
   endproperty
   a_wd_start: assert property (p_wd_start)
      else $error("watchdog not started by command");
   property p_wd_dead;
      $rose(exp_q) |-> !active_q ##1 (!active_q || $past(take));
   endproperty
   a_wd_dead: assert property (p_wd_dead)
      else $error("watchdog still active after expiry");
   property p_wd_closed;
      ce && active_q && closed && wd_cmd && wd.cmd_byte[3]
         |=> active_q && $stable(per_q) &&
             (cnt_q == $past(cnt_q) || cnt_q == $past(cnt_q) + 11'h001);
   endproperty
   a_wd_closed: assert property (p_wd_closed)
      else $error("clear accepted in closed window");
   property p_wd_exp;
      $rose(exp_q) |-> $past(cnt_q) == $past(limit) - 11'h001;
   endproperty
   a_wd_exp: assert property (p_wd_exp)
      else $error("expiry at wrong count");
   c_wd_exp: cover property ($rose(exp_q));
   c_wd_closed: cover property (active_q && closed && wd_cmd);
endmodule : wps_wdog

// ---- wps_host_model.sv ----
// Host-side model that hands watchdog command bytes to the block
`timescale 1ns/10ps
module wps_host_model (
   // Clock
   input  wire logic mclk,
   // Command bytes
   output logic [7:0] cmd_byte,
   output logic       cmd_valid
);
   // =========================================================
   // Bus idle at start: nothing valid
   initial begin
      cmd_valid = 1'b0;
      cmd_byte  = 8'h00;
   end

   // First byte, then the second on the very next edge
   // Idle byte is the inverse of the last, so stale data never matches
   task automatic send(input logic [7:0] b1, input logic [7:0] b2);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_byte  <= b1;
      @(posedge mclk);
      cmd_byte  <= b2;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      cmd_byte  <= ~b2;
   endtask : send
endmodule : wps_host_model

// ---- test_watchdog_and_power_sequencing_control.sv ----
// Self-checking bench for the watchdog and power-sequencing block
`timescale 1ns/10ps
module test_watchdog_and_power_sequencing_control;
   // =========================================================
   // Scaled time base: 40 cycles a tick, short deglitch
   localparam int MS = 40;
   localparam int DG = 8;
   // Sequencing steps: flags and expected regulator outputs
   localparam logic [5:0] FL [11] = '{6'h24, 6'h25, 6'h27, 6'h25,
      6'h24, 6'h26, 6'h24, 6'h0C, 6'h1C, 6'h0C, 6'h24};
   localparam logic [5:0] EX [11] = '{6'h30, 6'h20, 6'h22, 6'h22,
      6'h30, 6'h22, 6'h30, 6'h10, 6'h18, 6'h18, 6'h30};
   // Stimulus and observed signals
   logic        mclk, srst, ce, en_a, en_b, rc_done;
   logic [5:0]  cmp_std, cmp_inv;
   logic [1:0]  oor, op_mode;
   logic [7:0]  cmd_byte;
   logic        cmd_valid, rst_o, rst_oe, wd_act;
   logic        sw_en, lin_en, sw_sink, sw_shunt, lin_shunt, lin_sink;
   wire  [5:0]  reg_out = {sw_en, lin_en, sw_sink, sw_shunt,
                           lin_shunt, lin_sink};
   int          error_cnt, n_tests, n, i;
   logic [31:0] rnd;

   // =========================================================
   // Device and host
   wps_top #(.MS_CYCLES(MS), .DGL_CYCLES(DG)) u_wps_top (
      .MCLK(mclk), .SRST(srst), .CE(ce),
      .CMD_BYTE(cmd_byte), .CMD_VALID(cmd_valid),
      .ENABLE_SELECT_A(en_a), .ENABLE_SELECT_B(en_b),
      .CMP_STD(cmp_std), .CMP_INV(cmp_inv), .OUT_OF_REG(oor),
      .RC_TIMER_DONE(rc_done), .RESET_O(rst_o), .RESET_OE(rst_oe),
      .SW_EN(sw_en), .LIN_EN(lin_en), .SW_SINK_ON(sw_sink),
      .SW_SHUNT_ON(sw_shunt), .LIN_SHUNT_ON(lin_shunt),
      .LIN_SINK_ON(lin_sink), .WD_ACTIVE(wd_act), .OP_MODE(op_mode));
   wps_host_model u_wps_host_model (
      .mclk(mclk), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid));

   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // =========================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   // Inverted mode swaps the roles of the two regulators
   function automatic logic [5:0] inv_map(input logic [5:0] e);
      return {e[4], e[5], e[0], e[1], e[2], e[3]};
   endfunction : inv_map

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("mismatches %0d, comparisons %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   // Settle 1 ns past the edge so outputs are stable
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : cyc

   // Bounded wait on reset pin (w=0) or watchdog flag (w=1)
   task automatic wait_sig(input int w, input logic v, input int lim);
      n = 0;
      while (((w == 0) ? rst_oe : wd_act) !== v) begin
         if (n == lim) begin
            error_cnt++;
            $display("BAD t=%0t wait ran out", $time);
            complete_run();
         end
         cyc(1);
         n++;
      end
   endtask : wait_sig

   task automatic drive(input logic a, input logic b,
                        input logic [5:0] s, input logic [5:0] v);
      @(posedge mclk);
      en_a    <= a;
      en_b    <= b;
      cmp_std <= s;
      cmp_inv <= v;
      cyc(6);
   endtask : drive

   task automatic prog(input logic [7:0] b);
      u_wps_host_model.send(8'h60, b);
      #1;
   endtask : prog

   // Expiry: reset follows, held one delay, watchdog stays off
   task automatic expire;
      wait_sig(1, 1'b0, 4 * MS);
      wait_sig(0, 1'b1, 4);
      check({7'h0, rst_oe}, 8'h01);
      wait_sig(0, 1'b0, 12 * MS);
      check({7'h0, n >= 9 * MS && n <= 11 * MS + 8}, 8'h01);
      check({7'h0, wd_act}, 8'h00);
   endtask : expire

   // =========================================================
   // Main sequence
   initial begin
      error_cnt = 0;
      n_tests   = 0;
      rnd       = 32'h00002A62;
      srst      = 1'b1;
      ce        = 1'b1;
      en_a      = 1'b0;
      en_b      = 1'b0;
      rc_done   = 1'b0;
      cmp_std   = 6'h00;
      cmp_inv   = 6'h00;
      oor       = 2'h0;
      cyc(5);
      @(posedge mclk) srst <= 1'b0;
      cyc(1);
      check({rst_oe, rst_o, wd_act, op_mode, 3'h0}, 8'h80);
      check({2'h0, reg_out}, 8'h00);
      // Power-up reset waits for the external delay as well
      cyc(12 * MS);
      check({7'h0, rst_oe}, 8'h01);
      @(posedge mclk) rc_done <= 1'b1;
      wait_sig(0, 1'b0, 10);
      // Mode decode, every pin combination
      for (i = 0; i < 4; i++) begin
         drive(i[1], i[0], 6'h24, 6'h24);
         check({6'h0, op_mode}, i[7:0]);
         check({2'h0, reg_out}, (i == 0) ? 8'h00 : 8'h30);
      end
      // No sequencing: random flags change nothing
      for (i = 0; i < 8; i++) begin
         rnd = xs(rnd);
         drive(1'b1, 1'b1, rnd[5:0], rnd[11:6]);
         check({2'h0, reg_out}, 8'h30);
      end
      // Standard steps; inverted flags random and ignored
      for (i = 0; i < 11; i++) begin
         rnd = xs(rnd);
         drive(1'b0, 1'b1, FL[i], rnd[5:0]);
         check(8'(reg_out), 8'(EX[i]));
      end
      // Inverted steps, roles swapped
      for (i = 0; i < 11; i++) begin
         rnd = xs(rnd);
         drive(1'b1, 1'b0, rnd[5:0], FL[i]);
         check({2'h0, reg_out}, {2'h0, inv_map(EX[i])});
      end
      // Bytes without a valid first byte, and a bad second byte
      u_wps_host_model.send(8'h6B, 8'h6B);
      cyc(2);
      check({7'h0, wd_act}, 8'h00);
      prog(8'h61);
      check({7'h0, wd_act}, 8'h00);
      // Every period code switches on; off code switches off
      for (i = 0; i < 8; i++) begin
         prog(8'h68 + i[7:0]);
         check({7'h0, wd_act}, 8'h01);
         prog(8'h60);
         check({7'h0, wd_act}, 8'h00);
      end
      // 20 ms expiry; a low clock enable first freezes the count
      prog(8'h6B);
      @(posedge mclk) ce <= 1'b0;
      cyc(30 * MS);
      check({7'h0, wd_act}, 8'h01);
      @(posedge mclk) ce <= 1'b1;
      cyc(18 * MS);
      check({7'h0, wd_act}, 8'h01);
      expire();
      // Clear at 15 ms restarts the count from zero
      prog(8'h6B);
      cyc(15 * MS);
      prog(8'h6B);
      cyc(18 * MS);
      check({7'h0, wd_act}, 8'h01);
      expire();
      // Window: clear at 5 ms ignored, clear at 12 ms taken
      prog(8'h6F);
      cyc(5 * MS);
      prog(8'h6F);
      cyc(7 * MS);
      prog(8'h6F);
      cyc(17 * MS);
      check({7'h0, wd_act}, 8'h01);
      expire();
      // Longer period codes: alive 2 ms before the end, then expire
      for (i = 0; i < 3; i++) begin
         prog(8'h68 + i[7:0]);
         cyc((1280 >> (2 * i)) * MS - 2 * MS);
         check({7'h0, wd_act}, 8'h01);
         expire();
      end
      // Short out-of-regulation glitch is filtered
      @(posedge mclk) oor <= 2'b01;
      cyc(DG - 3);
      @(posedge mclk) oor <= 2'b00;
      cyc(20);
      check({7'h0, rst_oe}, 8'h00);
      // Lasting fault pulls reset, then full delay on recovery
      @(posedge mclk) oor <= 2'b10;
      wait_sig(0, 1'b1, DG + 8);
      check({7'h0, rst_oe}, 8'h01);
      @(posedge mclk) oor <= 2'b00;
      wait_sig(0, 1'b0, 12 * MS);
      check({7'h0, n >= 9 * MS}, 8'h01);
      complete_run();
   end
endmodule : test_watchdog_and_power_sequencing_control
